// ===== verilog/mqp_pkg.sv
package mqp_pkg;

	localparam int          DATA_W       = 32;
	localparam int          OFF_W        = 12;
	localparam logic [11:0] OFF_OP_STAT  = 12'h030;
	localparam logic [11:0] OFF_OP_MASK  = 12'h034;
	localparam logic [11:0] OFF_IN_Q     = 12'h040;
	localparam logic [11:0] OFF_OUT_Q    = 12'h044;
	localparam int          PEND_BIT     = 3;
	localparam int          MASK_BIT     = 3;
	localparam logic        MASK_RST     = 1'h1;
	localparam logic [31:0] EMPTY_WORD   = 32'hFFFFFFFF;
	localparam logic [31:0] ZERO_WORD    = 32'h00000000;

	localparam int          LIST_IW      = 4;
	localparam int          LIST_N       = 4;
	localparam logic [1:0]  L_IN_POST    = 2'h0;
	localparam logic [1:0]  L_IN_FREE    = 2'h1;
	localparam logic [1:0]  L_OUT_POST   = 2'h2;
	localparam logic [1:0]  L_OUT_FREE   = 2'h3;
	// list regions in local memory, entry i at base + 4*i
	localparam logic [3:0][31:0] LIST_BASE = {
		32'h00003000, 32'h00002000, 32'h00001000, 32'h00000000};
	localparam logic [4:0]  PTR_RST      = 5'h00;
	localparam int          FIFO_DEPTH   = 16;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} mqp_req_t;

	typedef struct packed {
		logic        ack;
		logic        retry;
		logic [31:0] rdata;
	} mqp_resp_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mqp_lb_t;

	typedef struct packed {
		logic [1:0]  list;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mqp_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BUSY = 2'h1,
		ST_DONE = 2'h3
	} mqp_state_t;

	typedef enum logic [1:0] {
		LB_IDLE = 2'h0,
		LB_ACT  = 2'h1
	} mqp_lb_state_t;

endpackage

// ===== verilog/mqp_top.sv
`timescale 1ns/10ps

module mqp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [PW:0]  wr_ptr;
	logic [PW:0]  rd_ptr;
	logic [PW:0]  next_wr_ptr;
	logic [PW:0]  next_rd_ptr;
	logic         full;
	logic         empty;
	logic         do_wr;
	logic         do_rd;

	always_comb begin
		empty = (wr_ptr == rd_ptr);
		full = (wr_ptr[PW] != rd_ptr[PW]) &&
			(wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
		in_ready_out = !full;
		out_valid_out = !empty;
		out_data_out = mem[rd_ptr[PW-1:0]];
		do_wr = in_valid_in && !full;
		do_rd = out_ready_in && !empty;
		next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// storage needs no reset, only pointers do
	always_ff @(posedge mclk_in) begin
		if (do_wr) begin
			mem[wr_ptr[PW-1:0]] <= in_data_in;
		end
	end

endmodule // mqp_fifo

module mqp_top (
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	input  wire mqp_pkg::mqp_req_t  req_in,
	output mqp_pkg::mqp_resp_t      resp_out,
	output mqp_pkg::mqp_lb_t        lb_out,
	input  wire logic               lb_done_in,
	input  wire logic [31:0]        lb_rdata_in,
	input  wire logic [3:0]         ext_adv_in,
	input  wire logic               mask_we_in,
	input  wire logic               mask_in,
	output logic                    irq_out
);
	import mqp_pkg::*;

	mqp_state_t          st;
	mqp_state_t          next_st;
	logic [1:0]          pend_list;
	logic [1:0]          next_pend_list;
	logic                pend_write;
	logic                next_pend_write;
	logic [31:0]         result;
	logic [31:0]         next_result;
	mqp_resp_t           next_resp;
	logic                mask;
	logic                next_mask;
	logic                next_irq;
	logic [4:0]          prod [LIST_N];
	logic [4:0]          cons [LIST_N];
	logic [4:0]          next_prod [LIST_N];
	logic [4:0]          next_cons [LIST_N];
	logic [LIST_N-1:0]   empty;
	logic [LIST_N-1:0]   full;
	logic [LIST_N-1:0]   dev_adv;
	logic                pending;
	logic                q_sel;
	logic [1:0]          acc_list;
	mqp_cmd_t            push_cmd;
	logic                push;
	logic                fifo_ready;
	mqp_cmd_t            pop_cmd;
	logic                pop_valid;
	logic                pop;
	mqp_lb_state_t       lst;
	mqp_lb_state_t       next_lst;
	mqp_lb_t             next_lb;
	logic [1:0]          cur_list;
	logic [1:0]          next_cur_list;
	logic                lb_fin;

	// writes go to a post list, reads to a free list
	function automatic logic [1:0] list_of(input logic [11:0] a,
			input logic w);
		logic out_port;
		out_port = (a == OFF_OUT_Q);
		list_of = {out_port, !w};
	endfunction

	function automatic logic [31:0] list_addr(input logic [1:0] l,
			input logic [4:0] p);
		list_addr = LIST_BASE[l] + {26'h0, p[3:0], 2'h0};
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < LIST_N; gi++) begin : g_occ
			logic [4:0] cnt;
			assign cnt = prod[gi] - cons[gi];
			assign empty[gi] = (cnt == 5'h00);
			assign full[gi] = cnt[4];
		end
	endgenerate

	assign pending = !empty[L_OUT_POST];
	assign q_sel = req_in.valid &&
		(req_in.addr == OFF_IN_Q || req_in.addr == OFF_OUT_Q);
	assign acc_list = list_of(req_in.addr, req_in.write);

	always_comb begin
		next_st = st;
		next_pend_list = pend_list;
		next_pend_write = pend_write;
		next_result = result;
		next_resp = '0;
		push = 1'b0;
		push_cmd.list = acc_list;
		push_cmd.we = req_in.write;
		push_cmd.addr = req_in.write ?
			list_addr(acc_list, prod[acc_list]) :
			list_addr(acc_list, cons[acc_list]);
		push_cmd.wdata = req_in.wdata;
		if (q_sel) begin
			case (st)
				ST_IDLE: begin
					next_resp.retry = 1'b1;
					if (req_in.write) begin
						if (!full[acc_list] && fifo_ready) begin
							push = 1'b1;
						end
					end else if (empty[acc_list]) begin
						next_resp.retry = 1'b0;
						next_resp.ack = 1'b1;
						next_resp.rdata = EMPTY_WORD;
					end else if (fifo_ready) begin
						push = 1'b1;
					end
					if (push) begin
						next_st = ST_BUSY;
						next_pend_list = acc_list;
						next_pend_write = req_in.write;
					end
				end
				ST_BUSY: begin
					next_resp.retry = 1'b1;
				end
				ST_DONE: begin
					if (acc_list == pend_list &&
							req_in.write == pend_write) begin
						next_resp.ack = 1'b1;
						next_resp.rdata = pend_write ? ZERO_WORD : result;
						next_st = ST_IDLE;
					end else begin
						next_resp.retry = 1'b1;
					end
				end
				default: begin
					next_st = ST_IDLE;
				end
			endcase
		end else if (req_in.valid) begin
			// status writes are ignored; the bit mirrors occupancy
			next_resp.ack = 1'b1;
			case (req_in.addr)
				OFF_OP_STAT: next_resp.rdata[PEND_BIT] = pending;
				OFF_OP_MASK: next_resp.rdata[MASK_BIT] = mask;
				default: next_resp.rdata = ZERO_WORD;
			endcase
		end
		// completion only happens while busy, so no clash above
		if (lb_fin) begin
			next_st = ST_DONE;
			next_result = lb_rdata_in;
		end
	end

	always_comb begin
		next_mask = mask_we_in ? mask_in : mask;
		next_irq = pending && !mask;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= ST_IDLE;
			pend_list <= 2'h0;
			pend_write <= 1'b0;
			result <= ZERO_WORD;
			resp_out <= '0;
			mask <= MASK_RST;
			irq_out <= 1'b0;
		end else begin
			st <= next_st;
			pend_list <= next_pend_list;
			pend_write <= next_pend_write;
			result <= next_result;
			resp_out <= next_resp;
			mask <= next_mask;
			irq_out <= next_irq;
		end
	end

	// one command in flight at most; the fifo still stalls the issue
	mqp_fifo #(
		.W     ($bits(mqp_cmd_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_in       (mclk_in),
		.rst_in        (rst_in),
		.in_valid_in   (push),
		.in_ready_out  (fifo_ready),
		.in_data_in    (push_cmd),
		.out_valid_out (pop_valid),
		.out_ready_in  (pop),
		.out_data_out  (pop_cmd)
	);

	assign lb_fin = (lst == LB_ACT) && lb_done_in;

	always_comb begin
		next_lst = lst;
		next_lb = lb_out;
		next_cur_list = cur_list;
		pop = 1'b0;
		dev_adv = '0;
		case (lst)
			LB_IDLE: begin
				if (pop_valid) begin
					pop = 1'b1;
					next_lb.req = 1'b1;
					next_lb.we = pop_cmd.we;
					next_lb.addr = pop_cmd.addr;
					next_lb.wdata = pop_cmd.wdata;
					next_cur_list = pop_cmd.list;
					next_lst = LB_ACT;
				end
			end
			LB_ACT: begin
				if (lb_done_in) begin
					next_lb.req = 1'b0;
					dev_adv[cur_list] = 1'b1;
					next_lst = LB_IDLE;
				end
			end
			default: begin
				next_lst = LB_IDLE;
			end
		endcase
	end

	always_comb begin
		for (int i = 0; i < LIST_N; i++) begin
			next_prod[i] = prod[i];
			next_cons[i] = cons[i];
			if (i % 2 == 0) begin
				if (dev_adv[i]) next_prod[i] = prod[i] + 5'h01;
				if (ext_adv_in[i] && !empty[i])
					next_cons[i] = cons[i] + 5'h01;
			end else begin
				if (ext_adv_in[i] && !full[i])
					next_prod[i] = prod[i] + 5'h01;
				if (dev_adv[i]) next_cons[i] = cons[i] + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			lst <= LB_IDLE;
			lb_out <= '0;
			cur_list <= 2'h0;
			for (int i = 0; i < LIST_N; i++) begin
				prod[i] <= PTR_RST;
				cons[i] <= PTR_RST;
			end
		end else begin
			lst <= next_lst;
			lb_out <= next_lb;
			cur_list <= next_cur_list;
			for (int i = 0; i < LIST_N; i++) begin
				prod[i] <= next_prod[i];
				cons[i] <= next_cons[i];
			end
		end
	end

endmodule // mqp_top

// ===== test/mqp_top_asserts.sv
`timescale 1ns/10ps
module mqp_top_chk (
	input wire logic               mclk_in,
	input wire logic               rst_in,
	input wire mqp_pkg::mqp_req_t  req_in,
	input wire mqp_pkg::mqp_resp_t resp_out,
	input wire mqp_pkg::mqp_lb_t   lb_out,
	input wire logic               lb_done_in,
	input wire logic [31:0]        lb_rdata_in,
	input wire logic [3:0]         ext_adv_in,
	input wire logic               mask_we_in,
	input wire logic               mask_in,
	input wire logic               irq_out
);
	import mqp_pkg::*;
	logic m;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// mask is internal and not among the ports bound here, so mirror it here
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			m <= MASK_RST;
		end else if (mask_we_in) begin
			m <= mask_in;
		end
	end
	sequence s_rd(a);
		req_in.valid && !req_in.write && req_in.addr == a;
	endsequence
	sequence s_lb_wait;
		lb_out.req && !lb_done_in;
	endsequence
	a_one_answer: assert property (
		req_in.valid |=> resp_out.ack ^ resp_out.retry) else $error("no answer");
	a_no_stray: assert property (
		resp_out.ack || resp_out.retry |-> $past(req_in.valid))
		else $error("answer without request");
	a_lb_hold: assert property (
		s_lb_wait |=> lb_out.req && $stable(lb_out)) else $error("lb unstable");
	a_lb_end: assert property (
		lb_out.req && lb_done_in |=> !lb_out.req) else $error("lb req stuck");
	a_lb_cause: assert property (
		$rose(lb_out.req) |-> $past(resp_out.retry)) else $error("lb unasked");
	a_post_addr: assert property (
		lb_out.req && lb_out.we |-> !lb_out.addr[12] && lb_out.addr[1:0] == 2'h0)
		else $error("post write off list");
	a_irq_mask: assert property (
		irq_out |-> !$past(m)) else $error("irq while masked");
	a_stat_read: assert property (
		s_rd(OFF_OP_STAT) |=> resp_out.ack && resp_out.rdata[31:4] == 28'h0
		&& resp_out.rdata[2:0] == 3'h0) else $error("status read");
	a_mask_read: assert property (
		s_rd(OFF_OP_MASK) |=> resp_out.ack
		&& resp_out.rdata == {28'h0, $past(m), 3'h0}) else $error("mask read");
endmodule // mqp_top_chk

bind mqp_top mqp_top_chk u_chk (.mclk_in, .rst_in, .req_in, .resp_out,
	.lb_out, .lb_done_in, .lb_rdata_in, .ext_adv_in, .mask_we_in, .mask_in,
	.irq_out);

// ===== test/mqp_mem_model.sv
`timescale 1ns/10ps
module mqp_mem_model (
	input  wire logic             mclk_in,
	input  wire mqp_pkg::mqp_lb_t lb_in,
	input  wire logic [3:0]       wait_in,
	output logic                  done_out,
	output logic [31:0]           rdata_out
);
	import mqp_pkg::*;
	logic [31:0] mem [logic [31:0]];
	logic [3:0]  cnt;
	initial begin
		cnt = 4'h0;
		done_out = 1'b0;
		rdata_out = 32'h0;
	end
	// idle data toggles so a stale value never passes for a read
	always @(posedge mclk_in) begin
		done_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (lb_in.req && !done_out) begin
			if (cnt == wait_in) begin
				cnt <= 4'h0;
				done_out <= 1'b1;
				if (lb_in.we) begin
					mem[lb_in.addr] = lb_in.wdata;
				end else begin
					rdata_out <= mem[lb_in.addr];
				end
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule // mqp_mem_model

// ===== test/tb_mqp_top.sv
`timescale 1ns/10ps
module tb_mqp_top;
	import mqp_pkg::*;
	localparam logic [31:0] PEND_W = 32'h1 << PEND_BIT;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	mqp_req_t    req = '0;
	mqp_resp_t   resp;
	mqp_lb_t     lb;
	logic        done;
	logic [31:0] rdata;
	logic [3:0]  adv = 4'h0;
	logic        mwe = 1'b0;
	logic        mval = 1'b0;
	logic        irq;
	logic [3:0]  lat = 4'h0;
	logic [31:0] q;
	logic        ok;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	always #5 mclk_in = ~mclk_in;
	mqp_top u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req),
		.resp_out(resp), .lb_out(lb), .lb_done_in(done), .lb_rdata_in(rdata),
		.ext_adv_in(adv), .mask_we_in(mwe), .mask_in(mval), .irq_out(irq));
	mqp_mem_model u_mem (.mclk_in(mclk_in), .lb_in(lb), .wait_in(lat),
		.done_out(done), .rdata_out(rdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, input int lim);
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			req = '{1'b1, w, a, d};
			@(negedge mclk_in);
			req.valid = 1'b0;
			ok = resp.ack;
			q = resp.rdata;
			@(negedge mclk_in);
		end
	endtask
	task automatic op(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] e);
		acc(w, a, d, 40);
		chk(ok, 1'b1);
		if (!w) chk(q, e);
	endtask
	task automatic pls(input logic [3:0] b);
		adv = b;
		@(negedge mclk_in);
		adv = 4'h0;
	endtask
	task automatic setm(input logic v);
		mwe = 1'b1;
		mval = v;
		@(negedge mclk_in);
		mwe = 1'b0;
		repeat (3) @(negedge mclk_in);
	endtask
	task automatic t_reset();
		op(0, OFF_OP_STAT, 0, ZERO_WORD);
		op(0, OFF_OP_MASK, 0, PEND_W);
		op(1, OFF_OP_MASK, 0, 0);
		op(0, OFF_OP_MASK, 0, PEND_W);
		chk(irq, 1'b0);
		op(0, OFF_IN_Q, 0, EMPTY_WORD);
		op(0, OFF_OUT_Q, 0, EMPTY_WORD);
		op(0, 12'h100, 0, ZERO_WORD);
	endtask
	task automatic t_out_post();
		lat = 4'h3;
		setm(1'b0);
		op(1, OFF_OUT_Q, 32'hA5A50001, 0);
		op(1, OFF_OUT_Q, 32'h5A5A0002, 0);
		chk(u_mem.mem[LIST_BASE[L_OUT_POST]], 32'hA5A50001);
		chk(u_mem.mem[LIST_BASE[L_OUT_POST] + 4], 32'h5A5A0002);
		op(0, OFF_OP_STAT, 0, PEND_W);
		chk(irq, 1'b1);
		setm(1'b1);
		chk(irq, 1'b0);
		op(0, OFF_OP_STAT, 0, PEND_W);
		op(1, OFF_OP_STAT, ZERO_WORD, ZERO_WORD);
		pls(4'h4);
		op(0, OFF_OP_STAT, 0, PEND_W);
		pls(4'h4);
		op(0, OFF_OP_STAT, 0, ZERO_WORD);
	endtask
	task automatic t_free(input logic [11:0] a, input logic [31:0] base,
		input logic [3:0] b);
		lat = 4'h0;
		u_mem.mem[base] = ~base;
		u_mem.mem[base + 4] = ~(base + 4);
		pls(b);
		pls(b);
		op(0, a, 0, ~base);
		op(0, a, 0, ~(base + 4));
		op(0, a, 0, EMPTY_WORD);
	endtask
	// slow memory keeps each post busy for several retries
	task automatic t_fill();
		lat = 4'h6;
		for (int i = 0; i < FIFO_DEPTH; i++) op(1, OFF_IN_Q, i, 0);
		for (int i = 0; i < FIFO_DEPTH; i++)
			chk(u_mem.mem[LIST_BASE[L_IN_POST] + 32'(4 * i)], 32'(i));
		acc(1, OFF_IN_Q, 32'hBEEF0000, 6);
		chk(ok, 1'b0);
		pls(4'h1);
		acc(1, OFF_IN_Q, 32'hBEEF0000, 1);
		chk(ok, 1'b0);
		repeat (20) @(negedge mclk_in);
		// a finished post blocks any other queue access
		acc(1'b0, OFF_OUT_Q, ZERO_WORD, 3);
		chk(ok, 1'b0);
		op(1, OFF_IN_Q, 32'hBEEF0000, 0);
		chk(u_mem.mem[LIST_BASE[L_IN_POST]], 32'hBEEF0000);
	endtask
	task automatic final_report();
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ceiling well above the few hundred cycles the run needs
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(negedge mclk_in);
		rst_in = 1'b0;
		t_reset();
		t_out_post();
		t_free(OFF_IN_Q, LIST_BASE[L_IN_FREE], 4'h2);
		t_free(OFF_OUT_Q, LIST_BASE[L_OUT_FREE], 4'h8);
		t_fill();
		final_report();
	end
endmodule // tb_mqp_top
